// *** design/cold_inrush_pkg.sv ***
// package: widths, reset values and timing constants of the cold load and inrush detector
package cold_inrush_pkg;
	// current values are multiples of the mode base with eight fraction bits
	localparam int CUR_W = 16;
	localparam int CUR_FRAC = 8;
	localparam int BASE_W = 16;
	localparam int PRIM_W = 24;
	localparam int PCT_W = 8;
	localparam int MS_W = 16;
	localparam int PHASES = 3;

	// clock and timing figures
	localparam int CLK_HZ = 125_000_000;
	localparam int MS_PER_S = 1000;
	localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
	localparam int START_WINDOW_MS = 80;
	localparam int FUND_CYCLE_MS = 20;

	// setting reset values
	localparam logic [MS_W-1:0] HOLD_RST = 16'h03E8;
	localparam logic [CUR_W-1:0] IDLE_RST = 16'h0020;
	localparam logic [CUR_W-1:0] PICK_RST = 16'h0080;
	localparam logic [PCT_W-1:0] HARM_RST = 8'h14;

	// sequence of the detector
	typedef enum logic [2:0] {
		stWaitIdle,
		stIdle,
		stRise,
		stActive,
		stTimeout
	} det_state_t;

	// editable settings, loaded together under password
	typedef struct packed {
		logic [MS_W-1:0] holdLimitTime;
		logic [CUR_W-1:0] idleCurrentLevel;
		logic [CUR_W-1:0] pickupLevel;
		logic [PCT_W-1:0] harmonicRatioThreshold;
	} settings_t;

	// status of one detection: start while active, trip on timeout
	typedef struct packed {
		logic start;
		logic trip;
	} det_status_t;
endpackage

// *** design/cold_load_inrush_detector.sv ***
// cold load pick-up and magnetising inrush detector with matrix routing
//
// Contract
// R1: cold load needs idle, then pick-up within 80ms
// R2: detection holds until max time or current drop
// R3: both detections feed output and blocking matrices
// R4: virtual outputs select alternate setting group
// R5: inrush needs cold start plus harmonic ratio
// R6: harmonic threshold percent, compared per phase
// R7: zero threshold makes inrush equal cold load
// R8: inrush starts on rise, continues on harmonic
// R9: supervised value is largest phase current
// R10: settings in base multiples, amperes readable
// R11: lingering between idle and pick-up blocks detection
// R12: status start while active, trip on timeout
// R13: settings change only with valid password
// R14: start window timed from first update after idle
// R15: reset clears all, fresh idle required; settings reload their reset values instead
module cold_load_inrush_detector #(
	parameter int MS_CYCLES = cold_inrush_pkg::MS_CYCLES,
	parameter int FUND_CYCLE_MS = cold_inrush_pkg::FUND_CYCLE_MS,
	parameter int STAGES = 8,
	parameter int VOUTS = 6
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// measurement path
	input wire logic measUpdate,
	input wire logic [cold_inrush_pkg::PHASES-1:0][cold_inrush_pkg::CUR_W-1:0] phaseCurrent,
	input wire logic [cold_inrush_pkg::PHASES-1:0][cold_inrush_pkg::PCT_W-1:0] secondHarmonicRatio,
	input wire logic [cold_inrush_pkg::BASE_W-1:0] modeCurrentBase,
	// settings write
	input wire logic settingsWrite,
	input wire logic passwordValid,
	input wire cold_inrush_pkg::settings_t settingsIn,
	// matrix configuration
	input wire logic [STAGES-1:0] coldBlockMask,
	input wire logic [STAGES-1:0] inrushBlockMask,
	input wire logic [VOUTS-1:0] coldVoutMask,
	input wire logic [VOUTS-1:0] inrushVoutMask,
	input wire logic [VOUTS-1:0] groupSelectMask,
	// detection and status
	output logic coldDetect,
	output logic inrushDetect,
	output cold_inrush_pkg::det_status_t coldLoadStatus,
	output cold_inrush_pkg::det_status_t inrushStatus,
	// readable values
	output logic [cold_inrush_pkg::CUR_W-1:0] peakPhaseCurrent,
	output logic [cold_inrush_pkg::PRIM_W-1:0] pickupPrimary,
	output logic [cold_inrush_pkg::PRIM_W-1:0] idlePrimary,
	output cold_inrush_pkg::settings_t settingsOut,
	// matrix outputs
	output logic [STAGES-1:0] stageBlock,
	output logic [VOUTS-1:0] virtualOut,
	output logic altSettingGroup
);
	localparam int TICK_W = $clog2(MS_CYCLES + 1);
	localparam int PROD_W = cold_inrush_pkg::CUR_W + cold_inrush_pkg::BASE_W;
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(MS_CYCLES - 1);
	localparam logic [cold_inrush_pkg::MS_W-1:0] WINDOW_MS =
		cold_inrush_pkg::MS_W'(cold_inrush_pkg::START_WINDOW_MS);
	localparam logic [cold_inrush_pkg::MS_W-1:0] CYCLE_MS =
		cold_inrush_pkg::MS_W'(FUND_CYCLE_MS);

	//////////////////////////////////////////////////////////////////////////////
	// reset release through two flip-flops
	logic rstMeta;
	logic rstSyncB;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rstMeta <= 1'b0;
			rstSyncB <= 1'b0;
		end else begin
			rstMeta <= 1'b1;
			rstSyncB <= rstMeta;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// settings
	cold_inrush_pkg::settings_t settings_reg;
	cold_inrush_pkg::settings_t settings_next;
	wire settingsLoad = settingsWrite & passwordValid;

	// R13: password gated load
	assign settings_next = settingsLoad ? settingsIn : settings_reg;

	always_ff @(posedge clk_sys or negedge rstSyncB) begin
		if (!rstSyncB) begin
			settings_reg <= '{holdLimitTime: cold_inrush_pkg::HOLD_RST,
				idleCurrentLevel: cold_inrush_pkg::IDLE_RST,
				pickupLevel: cold_inrush_pkg::PICK_RST,
				harmonicRatioThreshold: cold_inrush_pkg::HARM_RST};
		end else begin
			settings_reg <= settings_next;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// supervised value and per phase harmonic compare
	logic [cold_inrush_pkg::CUR_W-1:0] peak01;
	logic [cold_inrush_pkg::CUR_W-1:0] peakNow;
	logic [cold_inrush_pkg::PHASES-1:0] harmAbove;

	// R9: largest of the three phases
	assign peak01 = (phaseCurrent[0] > phaseCurrent[1]) ? phaseCurrent[0] : phaseCurrent[1];
	assign peakNow = (peak01 > phaseCurrent[2]) ? peak01 : phaseCurrent[2];

	// R6: ratio in percent against threshold, each phase
	for (genvar p = 0; p < cold_inrush_pkg::PHASES; p++) begin : g_harm
		assign harmAbove[p] = secondHarmonicRatio[p] > settings_reg.harmonicRatioThreshold;
	end

	wire allBelowIdle = peakNow < settings_reg.idleCurrentLevel;
	wire abovePickup = peakNow > settings_reg.pickupLevel;
	wire belowPickup = peakNow < settings_reg.pickupLevel;
	wire anyHarm = |harmAbove;
	wire harmOff = settings_reg.harmonicRatioThreshold == '0;

	//////////////////////////////////////////////////////////////////////////////
	// millisecond timebase, restarted on every state change
	cold_inrush_pkg::det_state_t state_reg;
	cold_inrush_pkg::det_state_t state_next;
	logic [TICK_W-1:0] tick_reg;
	logic [TICK_W-1:0] tick_next;
	logic [cold_inrush_pkg::MS_W-1:0] ms_reg;
	logic [cold_inrush_pkg::MS_W-1:0] ms_next;

	wire stateChange = state_next != state_reg;
	wire tickWrap = tick_reg == TICK_LAST;
	wire msSat = ms_reg == '1;

	assign tick_next = (stateChange || tickWrap) ? '0 : tick_reg + 1'b1;
	assign ms_next = stateChange ? '0 : (tickWrap && !msSat) ? ms_reg + 1'b1 : ms_reg;

	wire windowOver = ms_reg >= WINDOW_MS;
	wire holdOver = ms_reg >= settings_reg.holdLimitTime;
	wire firstCycleDone = ms_reg >= CYCLE_MS;

	//////////////////////////////////////////////////////////////////////////////
	// detection sequence
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			// R15: fresh idle interval before any detection
			cold_inrush_pkg::stWaitIdle: begin
				if (measUpdate && allBelowIdle) begin
					state_next = cold_inrush_pkg::stIdle;
				end
			end
			// R14: window starts at first update leaving idle
			cold_inrush_pkg::stIdle: begin
				if (measUpdate && !allBelowIdle) begin
					state_next = abovePickup ? cold_inrush_pkg::stActive : cold_inrush_pkg::stRise;
				end
			end
			// R1: pick-up reached inside the start window
			cold_inrush_pkg::stRise: begin
				if (windowOver) begin
					// R11: lingered too long, abandon this rise
					state_next = cold_inrush_pkg::stWaitIdle;
				end else if (measUpdate && abovePickup) begin
					state_next = cold_inrush_pkg::stActive;
				end else if (measUpdate && allBelowIdle) begin
					state_next = cold_inrush_pkg::stIdle;
				end
			end
			// R2: ends on max time or drop below pick-up
			cold_inrush_pkg::stActive: begin
				if (measUpdate && belowPickup) begin
					state_next = cold_inrush_pkg::stWaitIdle;
				end else if (holdOver) begin
					state_next = cold_inrush_pkg::stTimeout;
				end
			end
			cold_inrush_pkg::stTimeout: begin
				if (measUpdate && belowPickup) begin
					state_next = cold_inrush_pkg::stWaitIdle;
				end
			end
			default: state_next = cold_inrush_pkg::stWaitIdle;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstSyncB) begin
		if (!rstSyncB) begin
			state_reg <= cold_inrush_pkg::stWaitIdle;
			tick_reg <= '0;
			ms_reg <= '0;
		end else begin
			state_reg <= state_next;
			tick_reg <= tick_next;
			ms_reg <= ms_next;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// inrush qualification: once released after the first cycle it stays off for the rest of the active state
	logic inrushHeld_reg;
	logic inrushHeld_next;
	wire nextActive = state_next == cold_inrush_pkg::stActive;
	wire nextTimeout = state_next == cold_inrush_pkg::stTimeout;
	wire inActive = state_reg == cold_inrush_pkg::stActive;

	// R8: kept past first cycle only with harmonic or a zero threshold
	assign inrushHeld_next = !inActive ? 1'b1 :
		(firstCycleDone && !anyHarm && !harmOff) ? 1'b0 : inrushHeld_reg;

	// R5: cold start condition plus harmonic qualification
	// R7: zero threshold never releases
	// the timer still shows the previous state on entry, so entry counts as inside the first cycle
	wire inrushNext = nextActive && inrushHeld_next &&
		(harmOff || !inActive || !firstCycleDone || anyHarm);
	wire inrushTripNext = nextTimeout && inrushHeld_next;

	always_ff @(posedge clk_sys or negedge rstSyncB) begin
		if (!rstSyncB) begin
			inrushHeld_reg <= 1'b1;
		end else begin
			inrushHeld_reg <= inrushHeld_next;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// matrices
	logic [STAGES-1:0] blockNext;
	logic [VOUTS-1:0] voutNext;

	// R3: both detections feed the blocking matrix
	assign blockNext = ({STAGES{nextActive}} & coldBlockMask) |
		({STAGES{inrushNext}} & inrushBlockMask);
	// R3: and the output matrix virtual outputs
	assign voutNext = ({VOUTS{nextActive}} & coldVoutMask) |
		({VOUTS{inrushNext}} & inrushVoutMask);

	//////////////////////////////////////////////////////////////////////////////
	// primary scaled settings
	logic [PROD_W-1:0] pickProd;
	logic [PROD_W-1:0] idleProd;

	// R10: base multiple times base in amperes
	assign pickProd = PROD_W'(settings_reg.pickupLevel) * PROD_W'(modeCurrentBase);
	assign idleProd = PROD_W'(settings_reg.idleCurrentLevel) * PROD_W'(modeCurrentBase);

	//////////////////////////////////////////////////////////////////////////////
	// registered outputs
	always_ff @(posedge clk_sys or negedge rstSyncB) begin
		if (!rstSyncB) begin
			coldDetect <= 1'b0;
			inrushDetect <= 1'b0;
			coldLoadStatus <= '0;
			inrushStatus <= '0;
			stageBlock <= '0;
			virtualOut <= '0;
			altSettingGroup <= 1'b0;
		end else begin
			coldDetect <= nextActive;
			inrushDetect <= inrushNext;
			// R12: start while active, trip on timeout
			coldLoadStatus <= '{start: nextActive, trip: nextTimeout};
			inrushStatus <= '{start: inrushNext, trip: inrushTripNext};
			stageBlock <= blockNext;
			virtualOut <= voutNext;
			// R4: virtual outputs switch setting group
			altSettingGroup <= |(voutNext & groupSelectMask);
		end
	end

	// readable values
	always_ff @(posedge clk_sys or negedge rstSyncB) begin
		if (!rstSyncB) begin
			peakPhaseCurrent <= '0;
			pickupPrimary <= '0;
			idlePrimary <= '0;
			settingsOut <= '0;
		end else begin
			peakPhaseCurrent <= peakNow;
			pickupPrimary <= pickProd[cold_inrush_pkg::CUR_FRAC +: cold_inrush_pkg::PRIM_W];
			idlePrimary <= idleProd[cold_inrush_pkg::CUR_FRAC +: cold_inrush_pkg::PRIM_W];
			settingsOut <= settings_next;
		end
	end
endmodule

// *** dv/cold_inrush_sva.sv ***
// port checks of the cold load and inrush detector
module cold_inrush_sva #(
	parameter int STAGES = 8,
	parameter int VOUTS = 6
) (
	// clock, reset and inputs
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic measUpdate,
	input wire logic [2:0][15:0] phaseCurrent,
	input wire logic [15:0] modeCurrentBase,
	input wire logic settingsWrite,
	input wire logic passwordValid,
	input wire cold_inrush_pkg::settings_t settingsIn,
	input wire logic [STAGES-1:0] coldBlockMask,
	input wire logic [STAGES-1:0] inrushBlockMask,
	input wire logic [VOUTS-1:0] coldVoutMask,
	input wire logic [VOUTS-1:0] inrushVoutMask,
	input wire logic [VOUTS-1:0] groupSelectMask,
	// outputs
	input wire logic coldDetect,
	input wire logic inrushDetect,
	input wire cold_inrush_pkg::det_status_t coldLoadStatus,
	input wire cold_inrush_pkg::det_status_t inrushStatus,
	input wire logic [15:0] peakPhaseCurrent,
	input wire logic [23:0] pickupPrimary,
	input wire cold_inrush_pkg::settings_t settingsOut,
	input wire logic [STAGES-1:0] stageBlock,
	input wire logic [VOUTS-1:0] virtualOut,
	input wire logic altSettingGroup
);
	logic [2:0] relCnt;
	logic [15:0] m01;
	logic [15:0] pkExp;
	// cycles since release, skipping the reset synchroniser
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) relCnt <= 3'h0;
		else if (relCnt != 3'h5) relCnt <= relCnt + 3'h1;
	end
	// largest phase
	assign m01 = phaseCurrent[0] > phaseCurrent[1] ? phaseCurrent[0] : phaseCurrent[1];
	assign pkExp = m01 > phaseCurrent[2] ? m01 : phaseCurrent[2];
	default clocking @(posedge clk_sys); endclocking
	// settle past the synchroniser and the first load of the reset settings
	default disable iff (relCnt != 3'h5);
	////////////////////////////////////////////////////////////////////////////////
	a_peak_max: assert property (peakPhaseCurrent == $past(pkExp))
		else $error("peak current wrong");
	a_settings_load: assert property (settingsWrite && passwordValid |=> settingsOut == $past(settingsIn))
		else $error("settings not loaded");
	a_settings_hold: assert property (!(settingsWrite && passwordValid) |=> $stable(settingsOut))
		else $error("settings changed without password");
	a_primary_scale: assert property (pickupPrimary ==
		24'((32'($past(settingsOut.pickupLevel)) * 32'($past(modeCurrentBase))) >> 8))
		else $error("primary pickup wrong");
	a_rise_cause: assert property ($rose(coldDetect) |->
		$past(measUpdate) && peakPhaseCurrent > settingsOut.pickupLevel)
		else $error("detection without cause");
	a_block_gate: assert property (stageBlock == (({STAGES{coldDetect}} & $past(coldBlockMask))
		| ({STAGES{inrushDetect}} & $past(inrushBlockMask))))
		else $error("stage block wrong");
	a_vout_gate: assert property (virtualOut == (({VOUTS{coldDetect}} & $past(coldVoutMask))
		| ({VOUTS{inrushDetect}} & $past(inrushVoutMask))))
		else $error("virtual outputs wrong");
	a_alt_group: assert property ($stable(virtualOut) && $stable(groupSelectMask) |->
		altSettingGroup == |(virtualOut & groupSelectMask))
		else $error("group select wrong");
	a_zero_follow: assert property (settingsOut.harmonicRatioThreshold == 8'h00 |-> inrushDetect == coldDetect)
		else $error("inrush differs at zero threshold");
	a_inrush_start: assert property (inrushStatus.start == inrushDetect)
		else $error("inrush start status wrong");
	a_trip_after: assert property ($rose(coldLoadStatus.trip) |-> $past(coldLoadStatus.start) && !coldLoadStatus.start)
		else $error("trip without prior start");
endmodule
bind cold_load_inrush_detector cold_inrush_sva #(.STAGES(STAGES), .VOUTS(VOUTS)) cold_inrush_sva_i (.*);

// *** dv/meas_path_model.sv ***
// measurement path model: phase currents and harmonic ratios with update pulse
module meas_path_model (
	// clock
	input wire logic clk_sys,
	// measurement set
	output logic measUpdate,
	output logic [2:0][15:0] phaseCurrent,
	output logic [2:0][7:0] secondHarmonicRatio
);
	timeunit 1ns;
	timeprecision 1ps;
	// values stay as the latest measurement between updates
	initial begin
		measUpdate = 1'b0;
		phaseCurrent = '0;
		secondHarmonicRatio = '0;
	end
	// one update pulse carrying all three phases
	task automatic send(input logic [2:0][15:0] cur, input logic [2:0][7:0] rat);
		@(posedge clk_sys);
		measUpdate <= 1'b1;
		phaseCurrent <= cur;
		secondHarmonicRatio <= rat;
		@(posedge clk_sys);
		measUpdate <= 1'b0;
	endtask
endmodule

// *** dv/tb_cold_load_inrush_detector.sv ***
// self-checking bench of the cold load and inrush detector
module tb_cold_load_inrush_detector;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int MSC = 10;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic measUpdate, settingsWrite, passwordValid, coldDetect, inrushDetect, altSettingGroup;
	logic [2:0][15:0] phaseCurrent;
	logic [2:0][7:0] secondHarmonicRatio;
	logic [15:0] modeCurrentBase, peakPhaseCurrent, pk;
	logic [7:0] coldBlockMask, inrushBlockMask, stageBlock;
	logic [5:0] coldVoutMask, inrushVoutMask, groupSelectMask, virtualOut;
	logic [23:0] pickupPrimary, idlePrimary;
	cold_inrush_pkg::settings_t settingsIn, settingsOut, cfg;
	cold_inrush_pkg::det_status_t coldLoadStatus, inrushStatus;
	logic [31:0] seed = 32'h4A73;
	int n_mismatch = 0;
	int cmp_count = 0;
	always #4 clk_sys = ~clk_sys;
	cold_load_inrush_detector #(.MS_CYCLES(MSC), .FUND_CYCLE_MS(2)) cold_load_inrush_detector_i (.*);
	meas_path_model meas_path_model_i (.*);
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [15:0] max3(input logic [2:0][15:0] c);
		logic [15:0] m;
		m = c[0] > c[1] ? c[0] : c[1];
		return m > c[2] ? m : c[2];
	endfunction
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		if (n_mismatch == 0 && cmp_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// settings write, password as given
	task automatic wr(input logic pw, input cold_inrush_pkg::settings_t s);
		@(posedge clk_sys);
		settingsWrite <= 1'b1;
		passwordValid <= pw;
		settingsIn <= s;
		@(posedge clk_sys);
		settingsWrite <= 1'b0;
		#1;
	endtask
	// random rise with phase 0 always above pickup, phase 2 sometimes
	task automatic rise(input logic [7:0] r);
		logic [2:0][15:0] c;
		seed = lfsr(seed);
		c = {8'h00, seed[23:16], 9'h000, seed[14:8], 16'h0081 + seed[6:0]};
		pk = max3(c);
		meas_path_model_i.send(c, {8'h00, r, 8'h00});
		#1;
	endtask
	task automatic level(input logic [15:0] v);
		meas_path_model_i.send({3{v}}, '0);
	endtask
	task automatic waitc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// watchdog
	initial begin
		repeat (5000) @(posedge clk_sys);
		n_mismatch++;
		final_report();
	end
	// main sequence
	initial begin
		seed = lfsr(seed);
		{coldBlockMask, inrushBlockMask, coldVoutMask, inrushVoutMask} = seed[27:0];
		seed = lfsr(lfsr(seed));
		{groupSelectMask, modeCurrentBase} = {seed[5:0], seed[31:16]};
		{settingsWrite, passwordValid, settingsIn} = '0;
		cfg = '{16'h0005, 16'h0020, 16'h0080, 8'h14};
		waitc(2);
		rst_b <= 1'b1;
		waitc(3);
		wr(1'b0, '{16'h0009, 16'h0001, 16'h0002, 8'h03});
		chk(settingsOut, {16'h03E8, 16'h0020, 16'h0080, 8'h14});
		wr(1'b1, cfg);
		chk(settingsOut, cfg);
		waitc(1);
		chk(pickupPrimary, 24'((32'(cfg.pickupLevel) * 32'(modeCurrentBase)) >> 8));
		chk(idlePrimary, 24'((32'(cfg.idleCurrentLevel) * 32'(modeCurrentBase)) >> 8));
		rise(8'h50);
		chk(coldDetect, 1'b0);
		level(16'h0010);
		rise(8'h14);
		chk({coldDetect, inrushDetect, coldLoadStatus}, 4'b1110);
		chk(peakPhaseCurrent, pk);
		chk(stageBlock, coldBlockMask | inrushBlockMask);
		chk(virtualOut, coldVoutMask | inrushVoutMask);
		waitc(25);
		chk({coldDetect, inrushDetect}, 2'b10);
		chk(altSettingGroup, |(coldVoutMask & groupSelectMask));
		waitc(30);
		chk(coldLoadStatus, 2'b01);
		level(16'h0010);
		#1 chk({coldDetect, coldLoadStatus}, 3'b000);
		level(16'h0010);
		level(16'h0050);
		waitc(810);
		rise(8'h40);
		chk(coldDetect, 1'b0);
		level(16'h0010);
		level(16'h0050);
		waitc(20);
		rise(8'h40);
		chk(coldDetect, 1'b1);
		waitc(25);
		chk(inrushDetect, 1'b1);
		level(16'h0010);
		wr(1'b1, '{16'h0005, 16'h0020, 16'h0080, 8'h00});
		level(16'h0010);
		rise(8'h00);
		waitc(25);
		chk({coldDetect, inrushDetect}, 2'b11);
		final_report();
	end
endmodule
